//--- core/fpsf_defs.svh
`ifndef FPSF_DEFS_SVH
`define FPSF_DEFS_SVH

// Command codes on the data byte of a command write
`define FPSF_CMD_ERASE_SETUP 8'h80
`define FPSF_CMD_ERASE_GO    8'h10
`define FPSF_CMD_PROG_A      8'h40
`define FPSF_CMD_PROG_B      8'h10
`define FPSF_CMD_QUAD        8'h30
`define FPSF_CMD_CLR_STATUS  8'h50
`define FPSF_CMD_READ_STATUS 8'h70
`define FPSF_CMD_READ_ARRAY  8'hFF

// Status register bit positions
`define FPSF_SB_READY   7
`define FPSF_SB_ERASE   5
`define FPSF_SB_PROG    4
`define FPSF_SB_SUPPLY  3
`define FPSF_SB_PROTECT 1

// Status register reset value (errors clear, controller ready)
`define FPSF_STAT_RST 8'h80

// Embedded algorithm durations
`define FPSF_ERASE_CYC     4096
`define FPSF_PROG_TIME_NS  10000
`define FPSF_CLK_PERIOD_NS 10
`define FPSF_PROG_CYC      (`FPSF_PROG_TIME_NS / `FPSF_CLK_PERIOD_NS)

`endif

//--- core/fpsf_pkg.sv
package fpsf_pkg;

	// Address width of the byte-wide array
	localparam int FPSF_AW = 19;

	// One command write as taken from the multiplexed port
	typedef struct packed {
		logic [FPSF_AW-1:0] addr;
		logic [7:0]         data;
	} fpsf_wr_t;

	// Controller states, one-hot
	typedef enum logic [5:0] {
		FPSF_IDLE = 6'b000001,
		FPSF_ERA2 = 6'b000010,
		FPSF_ERA3 = 6'b000100,
		FPSF_PROG = 6'b001000,
		FPSF_QUAD = 6'b010000,
		FPSF_BUSY = 6'b100000
	} fpsf_state_t;

endpackage : fpsf_pkg

//--- core/fpsf_seq.sv
`timescale 1ns/100ps
`include "fpsf_defs.svh"
// Functional notes
// - Chip erase starts only after writes 80h, 80h, 10h; then erase runs.
// - After chip erase is accepted, reads return status without another command.
// - Status b7 reads 1 once the embedded operation has finished.
// - Invalid program supply during an operation sets status b3.
// - Improper command sequence sets b4 and b5 together.
// - Failed erase sets b5 with b4 left at 0.
// - Program reports protected block in b1 (not checked for quad program), supply b3, failure b4.
// - Quad program is accepted only when the multiplexed port is selected.
// - Chip erase is accepted only on the multiplexed port.
module fpsf_seq #(
	parameter int ERASE_CYC = `FPSF_ERASE_CYC,
	parameter int PROG_CYC  = `FPSF_PROG_CYC
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             wr_valid,
	input  wire fpsf_pkg::fpsf_wr_t wr,
	input  wire logic [7:0]       array_q,
	input  wire logic             array_fail,
	input  wire logic             prot_hit,
	input  wire logic             vpp_ok_pin,
	input  wire logic             mux_sel_pin,
	output logic [7:0]            rd_data_r,
	output logic                  ready_busy_output_r,
	output logic                  arr_wr_r,
	output fpsf_pkg::fpsf_wr_t    arr_wr_bus_r,
	output logic                  erase_all_r,
	output logic [7:0]            stat_r
);
	import fpsf_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic        vpp_m_r, vpp_s_r, sel_m_r, sel_s_r;

	// Supply and port select come from pins, so two flops each
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			vpp_m_r <= 1'b0;
			vpp_s_r <= 1'b0;
			sel_m_r <= 1'b0;
			sel_s_r <= 1'b0;
		end else begin
			vpp_m_r <= vpp_ok_pin;
			vpp_s_r <= vpp_m_r;
			sel_m_r <= mux_sel_pin;
			sel_s_r <= sel_m_r;
		end
	end

	// ****************************************
	// Controller state
	// ****************************************
	fpsf_state_t        st_r, st_nxt;
	logic [7:0]         err_r, err_nxt;
	logic               smode_r, smode_nxt;
	logic               kind_erase_r, kind_nxt;
	logic [31:0]        cnt_r, cnt_nxt;
	logic [1:0]         qidx_r, qidx_nxt;
	logic [FPSF_AW-1:0] qbase_r, qbase_nxt;
	logic               aw_nxt, ea_nxt;

	// Decoded write conditions
	wire [7:0] cmd       = wr.data;
	wire       quad_ok   = (qidx_r == 2'd0) ||
	                       ((wr.addr[FPSF_AW-1:2] == qbase_r[FPSF_AW-1:2]) &&
	                        (wr.addr[1:0] == qidx_r));
	wire       busy      = (st_r == FPSF_BUSY);
	wire [7:0] status    = {~busy, err_r[6:0]};

	// Sets an error group; sets never meet a clear since clear runs only idle
	function automatic logic [7:0] fpsf_flag(input logic [7:0] e, input int b);
		logic [7:0] r;
		r = e;
		r[b] = 1'b1;
		return r;
	endfunction : fpsf_flag

	// Next-state decode of command writes and embedded operation
	always_comb begin
		st_nxt    = st_r;
		err_nxt   = err_r;
		smode_nxt = smode_r;
		kind_nxt  = kind_erase_r;
		cnt_nxt   = busy ? cnt_r - 32'd1 : cnt_r;
		qidx_nxt  = qidx_r;
		qbase_nxt = qbase_r;
		aw_nxt    = 1'b0;
		ea_nxt    = 1'b0;
		case (st_r)
			FPSF_IDLE: begin
				if (wr_valid) begin
					if (cmd == `FPSF_CMD_ERASE_SETUP) begin
						st_nxt = FPSF_ERA2;
					end else if (cmd == `FPSF_CMD_PROG_A || cmd == `FPSF_CMD_PROG_B) begin
						st_nxt = FPSF_PROG;
					end else if (cmd == `FPSF_CMD_QUAD) begin
						if (sel_s_r) begin
							st_nxt   = FPSF_QUAD;
							qidx_nxt = 2'd0;
						end else begin
							err_nxt   = fpsf_flag(fpsf_flag(err_r, `FPSF_SB_PROG), `FPSF_SB_ERASE);
							smode_nxt = 1'b1;
						end
					end else if (cmd == `FPSF_CMD_CLR_STATUS) begin
						err_nxt[`FPSF_SB_PROTECT] = 1'b0;
						err_nxt[`FPSF_SB_SUPPLY]  = 1'b0;
						err_nxt[`FPSF_SB_PROG]    = 1'b0;
						err_nxt[`FPSF_SB_ERASE]   = 1'b0;
					end else if (cmd == `FPSF_CMD_READ_STATUS) begin
						smode_nxt = 1'b1;
					end else if (cmd == `FPSF_CMD_READ_ARRAY) begin
						smode_nxt = 1'b0;
					end
				end
			end
			FPSF_ERA2: begin
				if (wr_valid) begin
					if (cmd == `FPSF_CMD_ERASE_SETUP) begin
						st_nxt = FPSF_ERA3;
					end else begin
						err_nxt   = fpsf_flag(fpsf_flag(err_r, `FPSF_SB_PROG), `FPSF_SB_ERASE);
						smode_nxt = 1'b1;
						st_nxt    = FPSF_IDLE;
					end
				end
			end
			FPSF_ERA3: begin
				if (wr_valid) begin
					smode_nxt = 1'b1;
					st_nxt    = FPSF_IDLE;
					if (cmd != `FPSF_CMD_ERASE_GO || !sel_s_r) begin
						err_nxt = fpsf_flag(fpsf_flag(err_r, `FPSF_SB_PROG), `FPSF_SB_ERASE);
					end else if (!vpp_s_r) begin
						err_nxt = fpsf_flag(err_r, `FPSF_SB_SUPPLY);
					end else begin
						ea_nxt   = 1'b1;
						kind_nxt = 1'b1;
						cnt_nxt  = ERASE_CYC;
						st_nxt   = FPSF_BUSY;
					end
				end
			end
			FPSF_PROG: begin
				if (wr_valid) begin
					smode_nxt = 1'b1;
					st_nxt    = FPSF_IDLE;
					if (prot_hit) begin
						err_nxt = fpsf_flag(err_r, `FPSF_SB_PROTECT);
					end else if (!vpp_s_r) begin
						err_nxt = fpsf_flag(err_r, `FPSF_SB_SUPPLY);
					end else begin
						aw_nxt   = 1'b1;
						kind_nxt = 1'b0;
						cnt_nxt  = PROG_CYC;
						st_nxt   = FPSF_BUSY;
					end
				end
			end
			FPSF_QUAD: begin
				if (wr_valid) begin
					smode_nxt = 1'b1;
					if (!quad_ok) begin
						err_nxt = fpsf_flag(fpsf_flag(err_r, `FPSF_SB_PROG), `FPSF_SB_ERASE);
						st_nxt  = FPSF_IDLE;
					end else if (!vpp_s_r) begin
						err_nxt = fpsf_flag(err_r, `FPSF_SB_SUPPLY);
						st_nxt  = FPSF_IDLE;
					end else begin
						aw_nxt   = 1'b1;
						qidx_nxt = qidx_r + 2'd1;
						if (qidx_r == 2'd0) begin
							qbase_nxt = wr.addr;
						end
						if (qidx_r == 2'd3) begin
							kind_nxt = 1'b0;
							cnt_nxt  = PROG_CYC;
							st_nxt   = FPSF_BUSY;
						end
					end
				end
			end
			FPSF_BUSY: begin
				// Writes while busy are ignored; the array cannot take them
				if (!vpp_s_r) begin
					err_nxt = fpsf_flag(err_r, `FPSF_SB_SUPPLY);
					st_nxt  = FPSF_IDLE;
				end else if (cnt_r == 32'd0) begin
					st_nxt = FPSF_IDLE;
					if (array_fail) begin
						err_nxt = fpsf_flag(err_r, kind_erase_r ? `FPSF_SB_ERASE : `FPSF_SB_PROG);
					end
				end
			end
			default: begin
				st_nxt = FPSF_IDLE;
			end
		endcase
	end

	// Register update; outputs all come from flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r                <= FPSF_IDLE;
			err_r               <= `FPSF_STAT_RST & 8'h7F;
			smode_r             <= 1'b0;
			kind_erase_r        <= 1'b0;
			cnt_r               <= 32'd0;
			qidx_r              <= 2'd0;
			qbase_r             <= '0;
			arr_wr_r            <= 1'b0;
			arr_wr_bus_r        <= '0;
			erase_all_r         <= 1'b0;
			rd_data_r           <= 8'h00;
			ready_busy_output_r <= 1'b1;
			stat_r              <= `FPSF_STAT_RST;
		end else begin
			st_r                <= st_nxt;
			err_r               <= err_nxt;
			smode_r             <= smode_nxt;
			kind_erase_r        <= kind_nxt;
			cnt_r               <= cnt_nxt;
			qidx_r              <= qidx_nxt;
			qbase_r             <= qbase_nxt;
			arr_wr_r            <= aw_nxt;
			arr_wr_bus_r        <= wr;
			erase_all_r         <= ea_nxt;
			rd_data_r           <= smode_r ? status : array_q;
			ready_busy_output_r <= ~busy;
			stat_r              <= status;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence erase_go_s;
		st_r == FPSF_ERA3 && wr_valid && cmd == `FPSF_CMD_ERASE_GO && sel_s_r && vpp_s_r;
	endsequence

	erase_launch_a: assert property (@(posedge mclk) disable iff (rst)
		erase_go_s |=> erase_all_r && st_r == FPSF_BUSY)
		else $error("chip erase not launched");
	erase_port_a: assert property (@(posedge mclk) disable iff (rst)
		erase_all_r |-> $past(sel_s_r))
		else $error("chip erase outside mux port");
	erase_status_a: assert property (@(posedge mclk) disable iff (rst)
		erase_all_r |=> rd_data_r[`FPSF_SB_READY] == 1'b0 && !ready_busy_output_r)
		else $error("status not shown after erase");
	ready_bit_a: assert property (@(posedge mclk) disable iff (rst)
		$past(smode_r) |-> rd_data_r[`FPSF_SB_READY] == ready_busy_output_r)
		else $error("b7 disagrees with ready");
	supply_err_a: assert property (@(posedge mclk) disable iff (rst)
		busy && !vpp_s_r |=> err_r[`FPSF_SB_SUPPLY] && !busy)
		else $error("supply error not flagged");
	seq_err_a: assert property (@(posedge mclk) disable iff (rst)
		st_r == FPSF_ERA2 && wr_valid && cmd != `FPSF_CMD_ERASE_SETUP
		|=> err_r[`FPSF_SB_PROG] && err_r[`FPSF_SB_ERASE])
		else $error("sequence error not flagged");
	erase_fail_a: assert property (@(posedge mclk) disable iff (rst)
		busy && vpp_s_r && cnt_r == 32'd0 && array_fail && kind_erase_r && !err_r[`FPSF_SB_PROG]
		|=> err_r[`FPSF_SB_ERASE] && !err_r[`FPSF_SB_PROG])
		else $error("erase failure not flagged");
	protect_a: assert property (@(posedge mclk) disable iff (rst)
		st_r == FPSF_PROG && wr_valid && prot_hit |=> err_r[`FPSF_SB_PROTECT] && !arr_wr_r)
		else $error("protected write not rejected");
	quad_host_a: assert property (@(posedge mclk) disable iff (rst)
		st_r == FPSF_IDLE && wr_valid && cmd == `FPSF_CMD_QUAD && !sel_s_r
		|=> st_r == FPSF_IDLE ##1 !arr_wr_r)
		else $error("quad program on host port");
	clear_a: assert property (@(posedge mclk) disable iff (rst)
		st_r == FPSF_IDLE && wr_valid && cmd == `FPSF_CMD_CLR_STATUS
		|=> (err_r & 8'h3A) == 8'h00)
		else $error("status not cleared");

endmodule : fpsf_seq

//--- tb/fpsf_prog.sv
`timescale 1ns/100ps
// ****************************************
// Programmer model on the mux command port
// ****************************************
module fpsf_prog (
	input  wire logic          mclk,
	output fpsf_pkg::fpsf_wr_t wr,
	output logic               wr_valid
);
	import fpsf_pkg::*;
	initial begin
		wr_valid = 1'b0;
		wr = '0;
	end
	// One write, held across its taking edge; stale payload is inverted so it never looks valid
	task automatic send(input logic [FPSF_AW-1:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 wr_valid = 1'b1;
		wr = '{addr: a, data: d};
		@(posedge mclk);
		#1 wr_valid = 1'b0;
		wr = ~wr;
	endtask : send
endmodule : fpsf_prog

//--- tb/flash_program_erase_status_flow_bench.sv
`timescale 1ns/100ps
`include "fpsf_defs.svh"
module flash_program_erase_status_flow_bench;
	import fpsf_pkg::*;
	logic               mclk, rst, wr_valid, array_fail, prot_hit, vpp_ok_pin, mux_sel_pin;
	logic [7:0]         array_q, rd_data_r, stat_r;
	logic               ready_busy_output_r, arr_wr_r, erase_all_r;
	fpsf_wr_t           wr, arr_wr_bus_r;
	int                 errors = 0, cmp_count = 0, era_cnt = 0;
	fpsf_wr_t           exp_q[$];
	logic [FPSF_AW-1:0] base;
	logic [7:0]         est, dat;

	// Short counts keep the busy phases to a few cycles
	fpsf_seq #(.ERASE_CYC(8), .PROG_CYC(4)) i_dut (.mclk(mclk), .rst(rst),
		.wr_valid(wr_valid), .wr(wr), .array_q(array_q), .array_fail(array_fail),
		.prot_hit(prot_hit), .vpp_ok_pin(vpp_ok_pin), .mux_sel_pin(mux_sel_pin),
		.rd_data_r(rd_data_r), .ready_busy_output_r(ready_busy_output_r),
		.arr_wr_r(arr_wr_r), .arr_wr_bus_r(arr_wr_bus_r), .erase_all_r(erase_all_r),
		.stat_r(stat_r));
	fpsf_prog i_prog (.mclk(mclk), .wr(wr), .wr_valid(wr_valid));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("Error: %s expected %0h seen %0h", n, e, g);
			errors++;
		end
	endtask : chk

	task automatic end_sim();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// Array data kept below 80h so it can never be mistaken for a ready status read (b7 set)
	always @(posedge mclk) begin
		#1 array_q = 8'($urandom) & 8'h7F;
	end

	// Pulse monitor: erase launches counted, byte writes matched against the queue
	// Sampled on the falling edge so the pulses are settled
	always @(negedge mclk) begin
		if (erase_all_r === 1'b1) era_cnt++;
		if (arr_wr_r === 1'b1 && exp_q.size() == 0) chk("stray byte write", 0, 1);
		else if (arr_wr_r === 1'b1)
			chk("byte write", 32'(exp_q.pop_front()), 32'(arr_wr_bus_r));
	end

	// Bounded poll of ready, or of status b7 on the read path
	task automatic poll(input bit via_rd);
		int n;
		n = 0;
		repeat (3) @(posedge mclk);
		#1;
		while ((via_rd ? rd_data_r[7] : ready_busy_output_r) !== 1'b1 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 200) begin
			$display("Error: ready expected 1 seen %b", ready_busy_output_r);
			errors++;
			end_sim();
		end
	endtask : poll

	// Wait, ask for status, compare register and read path
	task automatic settle(string n, logic [7:0] e);
		poll(0);
		i_prog.send('0, `FPSF_CMD_READ_STATUS);
		repeat (2) @(posedge mclk);
		#1;
		chk(n, e, stat_r);
		chk({n, " read"}, e, rd_data_r);
		$display("Checked %s", n);
	endtask : settle

	// Read path in array mode returns the byte offered at the sampling edge
	task automatic arr_chk(string n);
		logic [7:0] q;
		@(posedge mclk);
		q = array_q;
		@(negedge mclk);
		chk(n, q, rd_data_r);
		$display("Checked %s", n);
	endtask : arr_chk

	task automatic clr();
		i_prog.send('0, `FPSF_CMD_CLR_STATUS);
		settle("cleared", `FPSF_STAT_RST);
	endtask : clr

	task automatic erase();
		i_prog.send('0, `FPSF_CMD_ERASE_SETUP);
		i_prog.send('0, `FPSF_CMD_ERASE_SETUP);
		i_prog.send('0, `FPSF_CMD_ERASE_GO);
	endtask : erase

	initial begin
		rst = 1'b1;
		array_q = 8'h00;
		array_fail = 1'b0;
		prot_hit = 1'b0;
		vpp_ok_pin = 1'b1;
		mux_sel_pin = 1'b1;
		void'($urandom(38296));
		repeat (6) @(posedge mclk);
		#1 rst = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		// Erase, good then failing; status appears without a read command
		for (int f = 0; f < 2; f++) begin
			array_fail = f[0];
			erase();
			poll(1);
			array_fail = 1'b0;
			chk("erase launches", f + 1, era_cnt);
			chk("erase status", f ? 8'hA0 : 8'h80, rd_data_r);
			clr();
		end
		// Program: plain, failing, protected, supply low, both setup codes
		for (int i = 0; i < 4; i++) begin
			base = FPSF_AW'($urandom);
			vpp_ok_pin = (i != 3);
			repeat (3) @(posedge mclk);
			#1 array_fail = (i == 1);
			dat = 8'($urandom);
			if (i < 2) exp_q.push_back(fpsf_wr_t'{addr: base, data: dat});
			i_prog.send('0, i[0] ? `FPSF_CMD_PROG_B : `FPSF_CMD_PROG_A);
			prot_hit = (i == 2);
			i_prog.send(base, dat);
			prot_hit = 1'b0;
			est = (i == 0) ? 8'h80 : (i == 1) ? 8'h90 : (i == 2) ? 8'h82 : 8'h88;
			settle("program status", est);
			array_fail = 1'b0;
			vpp_ok_pin = 1'b1;
			repeat (3) @(posedge mclk);
			clr();
		end
		// Broken erase sequence
		i_prog.send('0, `FPSF_CMD_ERASE_SETUP);
		i_prog.send('0, `FPSF_CMD_PROG_A);
		settle("bad sequence", 8'hB0);
		clr();
		// Erase and quad refused while the mux port is not selected
		mux_sel_pin = 1'b0;
		repeat (3) @(posedge mclk);
		erase();
		settle("erase unselected", 8'hB0);
		chk("no launch", 2, era_cnt);
		clr();
		i_prog.send('0, `FPSF_CMD_QUAD);
		settle("quad unselected", 8'hB0);
		clr();
		mux_sel_pin = 1'b1;
		repeat (3) @(posedge mclk);
		// Quad program on four consecutive addresses
		base = FPSF_AW'($urandom) & ~FPSF_AW'(3);
		i_prog.send('0, `FPSF_CMD_QUAD);
		for (int k = 0; k < 4; k++) begin
			dat = 8'($urandom);
			exp_q.push_back(fpsf_wr_t'{addr: base | FPSF_AW'(k), data: dat});
			i_prog.send(base | FPSF_AW'(k), dat);
		end
		settle("quad status", 8'h80);
		chk("quad bytes left", 0, exp_q.size());
		// Array mode: the read path goes back to array bytes
		i_prog.send('0, `FPSF_CMD_READ_ARRAY);
		arr_chk("array read");
		// Supply lost in mid-erase: the erase aborts with b3
		erase();
		vpp_ok_pin = 1'b0;
		settle("supply drop", 8'h88);
		vpp_ok_pin = 1'b1;
		repeat (3) @(posedge mclk);
		clr();
		// Reset in mid-erase: outputs take their reset values, read path shows the array
		erase();
		repeat (2) @(posedge mclk);
		#1 rst = 1'b1;
		#1;
		chk("launches", 4, era_cnt);
		chk("reset ready", 1, ready_busy_output_r);
		chk("reset status", `FPSF_STAT_RST, stat_r);
		chk("reset read", 0, rd_data_r);
		chk("reset launch", 0, erase_all_r);
		repeat (2) @(posedge mclk);
		#1 rst = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		arr_chk("array after reset");
		end_sim();
	end
endmodule : flash_program_erase_status_flow_bench
